// File: inc/pcs_pkg.sv
// Purpose: Shared constants and types for the pin check and string unit
// Assumes: One 20 MHz clock, registers on a plain strobe port
// Notes: Byte offsets, 32-bit data, low bits used
package pcs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MADDR_W = 20;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ACC = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_DEST = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;
  localparam logic [7:0] OFS_TBL_ADDR = 8'h18;
  localparam logic [7:0] OFS_TBL_CNT = 8'h1C;
  localparam logic [7:0] OFS_PLACE = 8'h20;
  localparam logic [7:0] OFS_INT_STAT = 8'h24;
  localparam logic [7:0] OFS_INT_MASK = 8'h28;

  // Control register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_DEC_BIT = 2;
  localparam logic [1:0] OP_CHECK = 2'h0;
  localparam logic [1:0] OP_FILL = 2'h1;
  localparam logic [1:0] OP_EXCH = 2'h2;
  localparam logic [1:0] OP_TABLE = 2'h3;

  // Program status flag positions
  localparam int FLG_S = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_AC = 4;
  localparam int FLG_PV = 2;
  localparam int FLG_CY = 0;

  // Interrupt status bits
  localparam int EV_W = 4;
  localparam int EV_DONE = 0;
  localparam int EV_SUSP = 1;
  localparam int EV_MISMATCH = 2;
  localparam int EV_ADDR_ERR = 3;

  // Data area placement settings and top addresses
  localparam logic [3:0] PLACE_LOW = 4'h0;
  localparam logic [3:0] PLACE_HIGH = 4'hF;
  localparam logic [19:0] MAX_ADDR_LOW = 20'h0FFFF;
  localparam logic [19:0] MAX_ADDR_HIGH = 20'hFFFFF;
  localparam logic [19:0] TBL_WIN_BELOW_MAX = 20'h001FF;
  localparam logic [19:0] TBL_STEP = 20'h00002;

  // Reset values
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [19:0] RST_DEST = 20'h00000;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [EV_W-1:0] RST_MASK = 4'h0;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_FILL = 4'h1,
    ST_XRD = 4'h2,
    ST_XWAIT = 4'h3,
    ST_XWR = 4'h4,
    ST_TRD = 4'h5,
    ST_TWAIT = 4'h6,
    ST_TWR = 4'h7,
    ST_SUSP_INT = 4'h8,
    ST_SUSP_MS = 4'h9
  } pcs_state_e;
endpackage

// File: rtl/pcs_core.sv
// Purpose: Pin level check into the accumulator and repeated string ops
// Assumes: Memory answers a read one cycle after mem_rd, never stalls
// Notes: Interrupt controller and other string ops live elsewhere
`timescale 1ns/1ps

module pcs_core
  import pcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [7:0] pin_level,
  input wire logic [7:0] port_latch,
  input wire logic [7:0] port_in_mode,
  output logic [MADDR_W-1:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic mem_wr,
  output logic mem_rd,
  output logic mem_word,
  input wire logic [15:0] mem_rdata,
  input wire logic irq_req,
  input wire logic ms_req,
  output logic irq_ack,
  output logic ms_ack,
  input wire logic int_return,
  input wire logic ms_done,
  output logic irq
);

  typedef struct packed {
    pcs_state_e st;
    logic [1:0] op;
    logic dec;
    logic place;
    logic [7:0] acc;
    logic [7:0] flags;
    logic [19:0] dest;
    logic [7:0] cnt;
    logic [19:0] taddr;
    logic [7:0] tcnt;
    logic [19:0] snap_dest;
    logic [7:0] snap_cnt;
    logic [EV_W-1:0] istat;
    logic [EV_W-1:0] imask;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [DATA_W-1:0] rdata;
    logic [MADDR_W-1:0] mem_addr;
    logic [15:0] mem_wdata;
    logic mem_wr;
    logic mem_rd;
    logic mem_word;
    logic irq_ack;
    logic ms_ack;
    logic irq;
  } pcs_s;

  pcs_s s;
  pcs_s next_s;

  logic [7:0] chk_xor;
  logic [19:0] step_dest;
  logic [7:0] cnt_dec;
  logic [19:0] win_base;
  logic sw_regs_ok;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] w1c;

  // Check result, input-mode pins forced to match
  assign chk_xor = (s.sync2 ^ port_latch) & ~port_in_mode;
  assign step_dest = s.dec ? s.dest - 20'h00001 : s.dest + 20'h00001;
  assign cnt_dec = s.cnt - 8'h01;
  // Window starts 1FFH below the top of the data area
  assign win_base = (s.place ? MAX_ADDR_HIGH : MAX_ADDR_LOW)
                    - TBL_WIN_BELOW_MAX;
  assign sw_regs_ok = (s.st == ST_IDLE) || (s.st == ST_SUSP_INT)
                      || (s.st == ST_SUSP_MS);

  always_comb begin
    next_s = s;
    ev = '0;
    w1c = '0;
    next_s.sync1 = pin_level;
    next_s.sync2 = s.sync1;
    next_s.mem_wr = 1'b0;
    next_s.mem_rd = 1'b0;
    next_s.irq_ack = 1'b0;
    next_s.ms_ack = 1'b0;
    next_s.rdata = '0;

    // Register reads
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: next_s.rdata = {29'h0, s.dec, s.op};
        OFS_STATUS: next_s.rdata = {28'h0, s.st};
        OFS_ACC: next_s.rdata = {24'h0, s.acc};
        OFS_FLAGS: next_s.rdata = {24'h0, s.flags};
        OFS_DEST: next_s.rdata = {12'h0, s.dest};
        OFS_COUNT: next_s.rdata = {24'h0, s.cnt};
        OFS_TBL_ADDR: next_s.rdata = {12'h0, s.taddr};
        OFS_TBL_CNT: next_s.rdata = {24'h0, s.tcnt};
        OFS_PLACE: next_s.rdata = s.place ? {28'h0, PLACE_HIGH}
                                          : {28'h0, PLACE_LOW};
        OFS_INT_STAT: next_s.rdata = {28'h0, s.istat};
        OFS_INT_MASK: next_s.rdata = {28'h0, s.imask};
        default: next_s.rdata = '0;
      endcase
    end

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        OFS_ACC: begin
          if (sw_regs_ok) begin
            next_s.acc = reg_wdata[7:0];
          end
        end
        OFS_FLAGS: begin
          if (sw_regs_ok) begin
            next_s.flags = reg_wdata[7:0];
          end
        end
        OFS_DEST: begin
          if (sw_regs_ok) begin
            next_s.dest = reg_wdata[19:0];
          end
        end
        OFS_COUNT: begin
          if (sw_regs_ok) begin
            next_s.cnt = reg_wdata[7:0];
          end
        end
        OFS_TBL_ADDR: begin
          if (s.st == ST_IDLE) begin
            next_s.taddr = reg_wdata[19:0];
          end
        end
        OFS_TBL_CNT: begin
          if (s.st == ST_IDLE) begin
            next_s.tcnt = reg_wdata[7:0];
          end
        end
        OFS_PLACE: begin
          // Other settings leave placement as it was
          if (reg_wdata[3:0] == PLACE_LOW) begin
            next_s.place = 1'b0;
          end else if (reg_wdata[3:0] == PLACE_HIGH) begin
            next_s.place = 1'b1;
          end
        end
        OFS_INT_STAT: w1c = reg_wdata[EV_W-1:0];
        OFS_INT_MASK: next_s.imask = reg_wdata[EV_W-1:0];
        default: begin
        end
      endcase
    end

    case (s.st)
      ST_IDLE: begin
        if (reg_wr && (reg_addr == OFS_CTRL)) begin
          next_s.op = reg_wdata[CTRL_OP_LSB+1:CTRL_OP_LSB];
          next_s.dec = reg_wdata[CTRL_DEC_BIT];
          case (reg_wdata[CTRL_OP_LSB+1:CTRL_OP_LSB])
            OP_CHECK: begin
              next_s.acc = chk_xor;
              next_s.flags[FLG_S] = chk_xor[7];
              next_s.flags[FLG_Z] = (chk_xor == 8'h00);
              next_s.flags[FLG_PV] = ~^chk_xor;
              // Aux carry and carry kept as they were
              ev[EV_DONE] = 1'b1;
              ev[EV_MISMATCH] = (chk_xor != 8'h00);
            end
            OP_FILL: next_s.st = ST_FILL;
            OP_EXCH: next_s.st = ST_XRD;
            OP_TABLE: begin
              if (s.taddr[19:8] == win_base[19:8]) begin
                next_s.st = ST_TRD;
              end else begin
                ev[EV_ADDR_ERR] = 1'b1;
              end
            end
            default: next_s.st = ST_IDLE;
          endcase
        end
      end
      ST_FILL: begin
        next_s.mem_wr = 1'b1;
        next_s.mem_word = 1'b0;
        next_s.mem_addr = s.dest;
        next_s.mem_wdata = {8'h00, s.acc};
        next_s.dest = step_dest;
        next_s.cnt = cnt_dec;
      end
      ST_XRD: begin
        next_s.mem_rd = 1'b1;
        next_s.mem_word = 1'b0;
        next_s.mem_addr = s.dest;
        next_s.st = ST_XWAIT;
      end
      ST_XWAIT: next_s.st = ST_XWR;
      ST_XWR: begin
        next_s.mem_wr = 1'b1;
        next_s.mem_addr = s.dest;
        next_s.mem_wdata = {8'h00, s.acc};
        next_s.acc = mem_rdata[7:0];
        next_s.dest = step_dest;
        next_s.cnt = cnt_dec;
        next_s.st = ST_XRD;
      end
      ST_TRD: begin
        next_s.mem_rd = 1'b1;
        next_s.mem_word = 1'b1;
        next_s.mem_addr = s.taddr;
        next_s.st = ST_TWAIT;
      end
      ST_TWAIT: next_s.st = ST_TWR;
      ST_TWR: begin
        next_s.mem_wr = 1'b1;
        next_s.mem_addr = s.taddr + TBL_STEP;
        next_s.mem_wdata = mem_rdata;
        next_s.taddr = s.taddr - TBL_STEP;
        next_s.tcnt = s.tcnt - 8'h01;
        if (s.tcnt == 8'h01) begin
          next_s.st = ST_IDLE;
          ev[EV_DONE] = 1'b1;
        end else begin
          next_s.st = ST_TRD;
        end
      end
      ST_SUSP_INT: begin
        if (int_return) begin
          if ((s.dest == s.snap_dest) && (s.cnt == s.snap_cnt)) begin
            next_s.st = (s.op == OP_FILL) ? ST_FILL : ST_XRD;
          end else begin
            next_s.st = ST_IDLE;
          end
        end
      end
      ST_SUSP_MS: begin
        if (ms_done) begin
          next_s.st = (s.op == OP_FILL) ? ST_FILL : ST_XRD;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase

    // End of a fill or exchange byte: finish, suspend or go on
    if ((s.st == ST_FILL) || (s.st == ST_XWR)) begin
      if (cnt_dec == 8'h00) begin
        next_s.st = ST_IDLE;
        ev[EV_DONE] = 1'b1;
      end else if (irq_req || ms_req) begin
        next_s.st = irq_req ? ST_SUSP_INT : ST_SUSP_MS;
        next_s.irq_ack = irq_req;
        next_s.ms_ack = ~irq_req;
        next_s.snap_dest = step_dest;
        next_s.snap_cnt = cnt_dec;
        ev[EV_SUSP] = 1'b1;
      end
    end

    // Hardware set wins over software clear
    next_s.istat = (s.istat & ~w1c) | ev;
    next_s.irq = |(next_s.istat & next_s.imask);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{
        st: ST_IDLE,
        op: OP_CHECK,
        dec: 1'b0,
        place: 1'b0,
        acc: RST_ACC,
        flags: RST_FLAGS,
        dest: RST_DEST,
        cnt: RST_COUNT,
        taddr: RST_DEST,
        tcnt: RST_COUNT,
        snap_dest: RST_DEST,
        snap_cnt: RST_COUNT,
        istat: '0,
        imask: RST_MASK,
        sync1: 8'h00,
        sync2: 8'h00,
        rdata: '0,
        mem_addr: '0,
        mem_wdata: 16'h0000,
        mem_wr: 1'b0,
        mem_rd: 1'b0,
        mem_word: 1'b0,
        irq_ack: 1'b0,
        ms_ack: 1'b0,
        irq: 1'b0
      };
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign mem_addr = s.mem_addr;
  assign mem_wdata = s.mem_wdata;
  assign mem_wr = s.mem_wr;
  assign mem_rd = s.mem_rd;
  assign mem_word = s.mem_word;
  assign irq_ack = s.irq_ack;
  assign ms_ack = s.ms_ack;
  assign irq = s.irq;

endmodule

// File: verif/pcs_mem_model.sv
// Purpose: Memory seen by the string unit
// Assumes: Read data due one cycle after mem_rd
// Notes: 4 KB image, low address bits only
`timescale 1ns/1ps
module pcs_mem_model
  import pcs_pkg::*;
(
  input wire logic clk,
  input wire logic [MADDR_W-1:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic mem_word,
  output logic [15:0] mem_rdata
);
  logic [7:0] m [0:4095];
  logic [11:0] a;
  assign a = mem_addr[11:0];
  initial begin
    mem_rdata = 16'h0000;
    for (int i = 0; i < 4096; i++) m[i] = i[7:0] ^ 8'hA5;
  end
  always @(posedge clk) begin
    if (mem_wr) begin
      m[a] <= mem_wdata[7:0];
      if (mem_word) m[a + 12'h001] <= mem_wdata[15:8];
    end
    // Stale data never stands still
    if (mem_rd) mem_rdata <= {mem_word ? m[a + 12'h001] : 8'h00, m[a]};
    else mem_rdata <= ~mem_rdata;
  end
endmodule

// File: verif/pcs_core_assertions.sv
// Purpose: Port checks for pcs_core
// Assumes: One clock, async low reset
// Notes: Step direction taken from CTRL writes
`timescale 1ns/1ps
module pcs_core_assertions
  import pcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [MADDR_W-1:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic mem_word,
  input wire logic [15:0] mem_rdata,
  input wire logic irq_ack,
  input wire logic ms_ack,
  input wire logic ms_done
);
  logic dec_q;
  logic ms_sus;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_q <= 1'b0;
      ms_sus <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == OFS_CTRL) dec_q <= reg_wdata[CTRL_DEC_BIT];
      if (ms_ack) ms_sus <= 1'b1;
      else if (ms_done) ms_sus <= 1'b0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Back-to-back byte writes only come from a fill
  sequence fill_pair;
    mem_wr && !mem_word && $past(mem_wr) && !$past(mem_word);
  endsequence
  exch_swap_a: assert property (
    mem_rd && !mem_word |-> ##2 mem_wr && mem_addr == $past(mem_addr, 2))
    else $error("exchange write address wrong");
  tbl_shift_a: assert property (
    mem_rd && mem_word |-> ##2 mem_wr && mem_word &&
    mem_addr == $past(mem_addr, 2) + TBL_STEP)
    else $error("table write address wrong");
  tbl_data_a: assert property (
    mem_rd && mem_word |-> ##2 mem_wdata == $past(mem_rdata))
    else $error("table write data wrong");
  fill_step_a: assert property (
    fill_pair |-> mem_addr == (dec_q ? $past(mem_addr) - 20'h00001
    : $past(mem_addr) + 20'h00001))
    else $error("fill pointer step wrong");
  fill_data_a: assert property (
    fill_pair |-> $stable(mem_wdata) && mem_wdata[15:8] == 8'h00)
    else $error("fill data changed");
  ack_write_a: assert property (
    irq_ack || ms_ack |-> mem_wr && !mem_word)
    else $error("ack not between bytes");
  ack_one_a: assert property (!(irq_ack && ms_ack))
    else $error("two acks at once");
  susp_quiet_a: assert property (
    irq_ack || ms_ack |=> (!mem_wr && !mem_rd) [*4])
    else $error("access while suspended");
  ms_resume_a: assert property (
    ms_done && ms_sus |-> ##[1:4] (mem_wr || mem_rd))
    else $error("no resume after service");
  cover property (irq_ack);
  cover property (ms_ack);
  cover property (mem_wr && mem_word);
endmodule
bind pcs_core pcs_core_assertions chk (.clk, .rst_b, .reg_addr,
  .reg_wdata, .reg_wr, .mem_addr, .mem_wdata, .mem_wr, .mem_rd,
  .mem_word, .mem_rdata, .irq_ack, .ms_ack, .ms_done);

// File: verif/pcs_core_test.sv
// Purpose: Self-checking bench for pcs_core
// Assumes: Memory model answers reads next cycle
// Notes: Check rows in a loop, string ops by hand
`timescale 1ns/1ps
module pcs_core_test
  import pcs_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic [7:0] pin_level = '0;
  logic [7:0] port_latch = '0;
  logic [7:0] port_in_mode = '0;
  logic [MADDR_W-1:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic mem_wr, mem_rd, mem_word, irq_ack, ms_ack, irq;
  logic irq_req = 1'b0;
  logic ms_req = 1'b0;
  logic int_return = 1'b0;
  logic ms_done = 1'b0;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] d;
  // Latch, pins, input mode, result, flags
  logic [39:0] rows [6] = '{40'h0000000055, 40'h8000008091,
    40'h0F0C000315, 40'hFF00F00F15, 40'hA55A00FF95, 40'h0100000111};
  logic [7:0] rofs [8] = '{OFS_ACC, OFS_FLAGS, OFS_DEST, OFS_COUNT,
    OFS_STATUS, OFS_INT_MASK, OFS_PLACE, 8'h30};
  logic [7:0] tw [6] = '{8'hAB, 8'hAA, 8'hAB, 8'hAA, 8'hB5, 8'hB4};
  pcs_core DUT (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pin_level, .port_latch, .port_in_mode, .mem_addr,
    .mem_wdata, .mem_wr, .mem_rd, .mem_word, .mem_rdata, .irq_req,
    .ms_req, .irq_ack, .ms_ack, .int_return, .ms_done, .irq);
  pcs_mem_model mem (.clk, .mem_addr, .mem_wdata, .mem_wr, .mem_rd,
    .mem_word, .mem_rdata);
  initial forever #25 clk = ~clk;
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      $display("[FAIL] %0t timeout", $time);
      err_total++;
      final_report;
    end
  end
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    ck(v, e);
  endtask
  task automatic mc(input logic [11:0] a, input logic [7:0] e);
    ck(32'(mem.m[a]), 32'(e));
  endtask
  task automatic ir(input logic e);
    repeat (2) @(posedge clk);
    #1 ck(32'(irq), 32'(e));
  endtask
  task automatic wait_idle;
    logic [31:0] s;
    s = 32'h1;
    for (int i = 0; i < 600 && s !== 32'h0; i++) rd(OFS_STATUS, s);
    ck(s, 32'h0);
  endtask
  task automatic wait_ack(input logic ms);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      if ((ms ? ms_ack : irq_ack) === 1'b1) break;
    end
    ck(32'(i < 40), 32'h1);
  endtask
  task automatic op(input logic [19:0] a, input logic [7:0] n,
    input logic [2:0] c);
    wr(OFS_DEST, 32'(a));
    wr(OFS_COUNT, 32'(n));
    wr(OFS_CTRL, 32'(c));
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rofs[k]) rc(rofs[k], 32'h0);
    $display("test reset done");
    wr(OFS_FLAGS, 32'h11);
    foreach (rows[k]) begin
      @(posedge clk);
      {port_latch, pin_level, port_in_mode} <= rows[k][39:16];
      repeat (4) @(posedge clk);
      wr(OFS_CTRL, 32'(OP_CHECK));
      rc(OFS_ACC, 32'(rows[k][15:8]));
      rc(OFS_FLAGS, 32'(rows[k][7:0]));
    end
    rd(OFS_INT_STAT, d);
    ck(d & 32'h4, 32'h4);
    wr(OFS_INT_MASK, 32'h4);
    ir(1'b1);
    wr(OFS_INT_MASK, 32'h0);
    ir(1'b0);
    wr(OFS_INT_STAT, 32'hF);
    wr(OFS_INT_MASK, 32'hF);
    ir(1'b0);
    $display("test check done");
    wr(OFS_ACC, 32'h3C);
    op(20'h00100, 8'h03, {1'b0, OP_FILL});
    wait_idle;
    for (int i = 0; i < 4; i++) begin
      mc(12'h100 + 12'(i), i < 3 ? 8'h3C : 8'hA6);
    end
    rc(OFS_DEST, 32'h103);
    rc(OFS_COUNT, 32'h0);
    rc(OFS_FLAGS, 32'h11);
    @(posedge clk);
    ms_req <= 1'b1;
    op(20'h00205, 8'h02, {1'b1, OP_FILL});
    wait_ack(1'b1);
    @(posedge clk);
    ms_req <= 1'b0;
    repeat (4) @(posedge clk);
    ms_done <= 1'b1;
    @(posedge clk);
    ms_done <= 1'b0;
    wait_idle;
    for (int i = 0; i < 3; i++) begin
      mc(12'h205 - 12'(i), i < 2 ? 8'h3C : 8'hA6);
    end
    rc(OFS_DEST, 32'h203);
    $display("test fill done");
    wr(OFS_ACC, 32'h77);
    @(posedge clk);
    irq_req <= 1'b1;
    op(20'h00300, 8'h03, {1'b0, OP_EXCH});
    wait_ack(1'b0);
    @(posedge clk);
    irq_req <= 1'b0;
    repeat (4) @(posedge clk);
    rc(OFS_STATUS, 32'h8);
    @(posedge clk);
    int_return <= 1'b1;
    @(posedge clk);
    int_return <= 1'b0;
    wait_idle;
    for (int i = 0; i < 3; i++) begin
      mc(12'h300 + 12'(i), i == 0 ? 8'h77 : 8'hA5 ^ 8'(i - 1));
    end
    rc(OFS_ACC, 32'hA7);
    $display("test exchange done");
    // Pointer moved during suspension: return must abort
    wr(OFS_INT_STAT, 32'hF);
    @(posedge clk);
    irq_req <= 1'b1;
    op(20'h00400, 8'h03, {1'b1, OP_EXCH});
    wait_ack(1'b0);
    @(posedge clk);
    irq_req <= 1'b0;
    wr(OFS_DEST, 32'h003FE);
    @(posedge clk);
    int_return <= 1'b1;
    @(posedge clk);
    int_return <= 1'b0;
    repeat (2) @(posedge clk);
    rc(OFS_STATUS, 32'h0);
    rd(OFS_INT_STAT, d);
    ck(d & 32'h3, 32'h2);
    mc(12'h400, 8'hA7);
    mc(12'h3FF, 8'h5A);
    rc(OFS_ACC, 32'hA5);
    rc(OFS_COUNT, 32'h2);
    $display("test abort done");
    wr(OFS_TBL_ADDR, 32'h0FE10);
    wr(OFS_TBL_CNT, 32'h2);
    wr(OFS_CTRL, 32'(OP_TABLE));
    wait_idle;
    for (int i = 0; i < 6; i++) begin
      mc(12'hE0E + 12'(i), tw[i]);
    end
    wr(OFS_INT_STAT, 32'hF);
    wr(OFS_PLACE, 32'hF);
    wr(OFS_CTRL, 32'(OP_TABLE));
    wait_idle;
    rd(OFS_INT_STAT, d);
    ck(d & 32'h8, 32'h8);
    mc(12'hE12, 8'hB5);
    rc(OFS_PLACE, 32'hF);
    $display("test table done");
    final_report;
  end
endmodule
